// [hdl/mbld_pkg.sv]
/*
 * Shared constants and types for the microcore branch and load decode block:
 * opcode patterns, field positions, reset values, APB register offsets and carriers.
 * Assumes a 16-bit instruction word and a 10-bit code RAM address.
 */
package mbld_pkg;

    localparam int PC_W = 10;
    localparam int DA_W = 6;

    typedef logic [15:0]     mbld_word_t;
    typedef logic [PC_W-1:0] mbld_pc_t;
    typedef logic [DA_W-1:0] mbld_daddr_t;

    // opcode patterns: (word & mask) == value
    localparam mbld_word_t JMP_MASK  = 16'hFC00;
    localparam mbld_word_t JMP_VAL   = 16'h3000;
    localparam mbld_word_t JTSF_MASK = 16'hFFF7;
    localparam mbld_word_t JTSF_VAL  = 16'h39B5;
    localparam mbld_word_t JTSR_MASK = 16'hFFE0;
    localparam mbld_word_t JTSR_VAL  = 16'h2F20;
    localparam mbld_word_t LDCA_MASK = 16'hE007;
    localparam mbld_word_t LDCA_VAL  = 16'hA004;
    localparam mbld_word_t LDCD_MASK = 16'hC000;
    localparam mbld_word_t LDCD_VAL  = 16'h4000;
    localparam mbld_word_t LDIH_MASK = 16'hF803;
    localparam mbld_word_t LDIH_VAL  = 16'h3803;
    localparam mbld_word_t LDIL_MASK = 16'hF803;
    localparam mbld_word_t LDIL_VAL  = 16'h3802;

    // field positions
    localparam int POL_BIT   = 9;
    localparam int SSEL_HI   = 8;
    localparam int SSEL_LO   = 5;
    localparam int OFS_HI    = 4;
    localparam int OFS_LO    = 0;
    localparam int FAR_BIT   = 3;
    localparam int MODE_BIT  = 13;
    localparam int CLR_BIT   = 12;
    localparam int SC1_HI    = 11;
    localparam int SC1_LO    = 10;
    localparam int SC2_HI    = 9;
    localparam int SC2_LO    = 8;
    localparam int TSEL_HI   = 7;
    localparam int TSEL_LO   = 6;
    localparam int SRC_HI    = 5;
    localparam int SRC_LO    = 3;
    localparam int DRAM_HI   = 5;
    localparam int DRAM_LO   = 0;
    localparam int BCLR_BIT  = 10;
    localparam int LIT_HI    = 9;
    localparam int LIT_LO    = 2;

    // reset values
    localparam mbld_pc_t   PC_RST   = 10'h000;
    localparam mbld_word_t WORD_RST = 16'h0000;
    localparam logic       EN_RST   = 1'b1;

    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_FAR1  = 8'h04;
    localparam logic [7:0] OFS_FAR2  = 8'h08;
    localparam logic [7:0] OFS_IMM   = 8'h0C;
    localparam logic [7:0] OFS_PC    = 8'h10;
    localparam logic [7:0] OFS_RET   = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;
    localparam logic [7:0] OFS_TC0   = 8'h20;

    typedef enum logic [1:0] {
        SC_KEEP   = 2'h0,
        SC_OFF    = 2'h1,
        SC_ON     = 2'h2,
        SC_TOGGLE = 2'h3
    } mbld_sc_e;

    typedef enum logic {ST_IDLE, ST_MEM_WAIT} mbld_state_e;

    typedef struct packed {
        logic       valid;
        mbld_word_t word;
        mbld_pc_t   addr;
    } mbld_instr_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mbld_apb_req_s;

endpackage

// [hdl/mbld_decode.sv]
/*
 * Decode and execute of the status jump, subroutine calls, terminal count loads
 * and immediate byte loads, with an APB register window.
 * Assumes the fetch datapath presents one instruction with its code RAM address,
 * the ALU register file and status word on the same clock, and a data RAM that
 * answers a read with dram_rvalid some cycles later.
 */
// How it works
// - word 001100xxxx is the status jump: polarity, status select, offset.
// - relative target is instruction address plus signed 5-bit offset.
// - far call loads the counter from the selected far target register.
// - far call pattern 001110011011x101; bit 3 picks the far target.
// - both calls save the current address into the return register.
// - relative call pattern 00101111001 with offset in bits 4..0.
// - ALU count load writes the ALU register and applies both shortcut actions.
// - ALU count load 101...100: clear, actions, select, source fields.
// - clear flag zeroes the chosen counter; otherwise only the threshold changes.
// - shortcut action is keep, off, on or invert.
// - memory count load writes data RAM word and applies both shortcut actions.
// - indexed mode adds the index base to the data RAM address.
// - memory count load is 01 in bits 15..14 with mode, clear, actions, address.
// - upper byte load sets immediate bits 15..8, optionally clears low byte.
// - upper byte load 00111 ... 11, clear at bit 10, literal at 9..2.
// - lower byte load sets immediate bits 7..0, optionally clears high byte.
// - lower byte load same layout with bits 1..0 equal 10.
// - two-bit select picks one of four terminal count registers.
// - jump condition met when status bit equals polarity.
// - two 10-bit far target registers hold call destinations.
`timescale 1ns/100ps
module mbld_decode (
    // clock, reset, enable
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   ce,
    // instruction from fetch
    input  wire mbld_pkg::mbld_instr_s  instr,
    output logic                        instr_ready_q,
    output logic                        done_q,
    output logic                        hit_q,
    // datapath operands
    input  wire logic [15:0]            status_word,
    input  wire mbld_pkg::mbld_word_t [7:0] alu_regs,
    input  wire mbld_pkg::mbld_daddr_t  index_base,
    // data RAM read
    output mbld_pkg::mbld_daddr_t       dram_addr_q,
    output logic                        dram_rd_q,
    input  wire logic                   dram_rvalid,
    input  wire mbld_pkg::mbld_word_t   dram_rdata,
    // results
    output mbld_pkg::mbld_pc_t          program_counter_q,
    output mbld_pkg::mbld_pc_t          return_addr_q,
    output mbld_pkg::mbld_word_t        immediate_operand_register_q,
    output mbld_pkg::mbld_word_t [3:0]  terminal_count_q,
    output logic [3:0]                  counter_clear_q,
    output logic [1:0]                  shortcut_q,
    // APB slave
    input  wire mbld_pkg::mbld_apb_req_s apb,
    output logic [31:0]                 prdata_q,
    output logic                        pready_q,
    output logic                        pslverr_q
);
    import mbld_pkg::*;

    mbld_state_e state_q;
    mbld_pc_t    far_target_one_q;
    mbld_pc_t    far_target_two_q;
    logic        decode_en_q;
    logic [1:0]  mem_sel_q;
    logic        mem_clr_q;
    logic [1:0]  mem_sc1_q;
    logic [1:0]  mem_sc2_q;

    logic        accept;
    logic        is_jmp;
    logic        is_jtsf;
    logic        is_jtsr;
    logic        is_ldca;
    logic        is_ldcd;
    logic        is_ldih;
    logic        is_ldil;
    logic        jmp_met;
    logic        mem_done;
    logic        apb_done;
    mbld_pc_t    rel_target;
    mbld_pc_t    seq_next;
    mbld_pc_t    far_target;
    mbld_word_t  w;
    logic [1:0]  tc_sel;
    logic        clr_flag;
    logic [1:0]  sc1_action;
    logic [1:0]  sc2_action;
    logic [2:0]  source_reg_index;
    mbld_daddr_t dram_field;

    function automatic logic apply_sc(input logic cur, input logic [1:0] act);
        logic r;
        r = cur;
        case (act)
            SC_OFF:    r = 1'b0;
            SC_ON:     r = 1'b1;
            SC_TOGGLE: r = ~cur;
            default:   r = cur;
        endcase
        return r;
    endfunction

    always_comb begin
        w          = instr.word;
        accept     = ce && instr.valid && instr_ready_q;
        mem_done   = ce && (state_q == ST_MEM_WAIT) && dram_rvalid;
        is_jmp     = (w & JMP_MASK) == JMP_VAL;
        is_jtsf    = (w & JTSF_MASK) == JTSF_VAL;
        is_jtsr    = (w & JTSR_MASK) == JTSR_VAL;
        is_ldca    = (w & LDCA_MASK) == LDCA_VAL;
        is_ldcd    = (w & LDCD_MASK) == LDCD_VAL;
        is_ldih    = (w & LDIH_MASK) == LDIH_VAL;
        is_ldil    = (w & LDIL_MASK) == LDIL_VAL;
        jmp_met    = status_word[w[SSEL_HI:SSEL_LO]] == w[POL_BIT];
        // sign-extend then wrap at counter width
        rel_target = instr.addr + {{(PC_W-5){w[OFS_HI]}}, w[OFS_HI:OFS_LO]};
        seq_next   = instr.addr + 10'h001;
        far_target = w[FAR_BIT] ? far_target_two_q : far_target_one_q;
        tc_sel           = w[TSEL_HI:TSEL_LO];
        clr_flag         = w[CLR_BIT];
        sc1_action       = w[SC1_HI:SC1_LO];
        sc2_action       = w[SC2_HI:SC2_LO];
        source_reg_index = w[SRC_HI:SRC_LO];
        dram_field       = w[DRAM_HI:DRAM_LO];
        apb_done         = ce && apb.psel && apb.penable && pready_q;
    end

    // program flow: counter, return address, completion flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            program_counter_q <= PC_RST;
            return_addr_q     <= PC_RST;
            done_q            <= 1'b0;
            hit_q             <= 1'b0;
        end else if (ce) begin
            done_q <= 1'b0;
            hit_q  <= 1'b0;
            if (mem_done) begin
                done_q <= 1'b1;
                hit_q  <= 1'b1;
            end
            if (accept) begin
                // a memory count load signals completion when the RAM word arrives
                done_q <= !is_ldcd;
                hit_q  <= is_jmp | is_jtsf | is_jtsr | is_ldca | is_ldih | is_ldil;
                if (is_jmp) begin
                    program_counter_q <= jmp_met ? rel_target : seq_next;
                end else if (is_jtsf) begin
                    return_addr_q     <= instr.addr;
                    program_counter_q <= far_target;
                end else if (is_jtsr) begin
                    return_addr_q     <= instr.addr;
                    program_counter_q <= rel_target;
                end else if (is_ldca | is_ldcd | is_ldih | is_ldil) begin
                    program_counter_q <= seq_next;
                end
            end
        end
    end

    // data RAM read sequencing and instruction back-pressure
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q       <= ST_IDLE;
            instr_ready_q <= 1'b0;
            dram_rd_q     <= 1'b0;
            dram_addr_q   <= '0;
            mem_sel_q     <= 2'h0;
            mem_clr_q     <= 1'b0;
            mem_sc1_q     <= SC_KEEP;
            mem_sc2_q     <= SC_KEEP;
        end else if (ce) begin
            dram_rd_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    instr_ready_q <= decode_en_q;
                    if (accept && is_ldcd) begin
                        state_q       <= ST_MEM_WAIT;
                        instr_ready_q <= 1'b0;
                        dram_rd_q     <= 1'b1;
                        // index base wraps within the 6-bit data RAM space
                        dram_addr_q   <= w[MODE_BIT] ? dram_field + index_base
                                                     : dram_field;
                        mem_sel_q     <= tc_sel;
                        mem_clr_q     <= clr_flag;
                        mem_sc1_q     <= sc1_action;
                        mem_sc2_q     <= sc2_action;
                    end
                end
                ST_MEM_WAIT: begin
                    if (dram_rvalid) begin
                        state_q       <= ST_IDLE;
                        instr_ready_q <= decode_en_q;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // terminal count thresholds and counter restart pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            terminal_count_q <= '0;
            counter_clear_q  <= 4'h0;
        end else if (ce) begin
            counter_clear_q <= 4'h0;
            if (accept && is_ldca) begin
                terminal_count_q[tc_sel] <= alu_regs[source_reg_index];
                counter_clear_q[tc_sel]  <= clr_flag;
            end else if (mem_done) begin
                terminal_count_q[mem_sel_q] <= dram_rdata;
                counter_clear_q[mem_sel_q]  <= mem_clr_q;
            end
        end
    end

    // output shortcut states
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shortcut_q <= 2'h0;
        end else if (ce) begin
            if (accept && is_ldca) begin
                shortcut_q[0] <= apply_sc(shortcut_q[0], sc1_action);
                shortcut_q[1] <= apply_sc(shortcut_q[1], sc2_action);
            end else if (mem_done) begin
                shortcut_q[0] <= apply_sc(shortcut_q[0], mem_sc1_q);
                shortcut_q[1] <= apply_sc(shortcut_q[1], mem_sc2_q);
            end
        end
    end

    // immediate operand register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            immediate_operand_register_q <= WORD_RST;
        end else if (ce && accept) begin
            if (is_ldih) begin
                immediate_operand_register_q[15:8] <= w[LIT_HI:LIT_LO];
                if (w[BCLR_BIT]) begin
                    immediate_operand_register_q[7:0] <= 8'h00;
                end
            end else if (is_ldil) begin
                immediate_operand_register_q[7:0] <= w[LIT_HI:LIT_LO];
                if (w[BCLR_BIT]) begin
                    immediate_operand_register_q[15:8] <= 8'h00;
                end
            end
        end
    end

    // APB slave: one wait state, pready and read data from flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_q         <= 1'b0;
            pslverr_q        <= 1'b0;
            prdata_q         <= 32'h0000_0000;
            decode_en_q      <= EN_RST;
            far_target_one_q <= PC_RST;
            far_target_two_q <= PC_RST;
        end else if (ce) begin
            pready_q  <= apb.psel && apb.penable && !pready_q;
            pslverr_q <= 1'b0;
            if (apb.psel && apb.penable && !pready_q) begin
                prdata_q <= 32'h0000_0000;
                if (apb.paddr == OFS_CTRL) begin
                    prdata_q[0] <= decode_en_q;
                end else if (apb.paddr == OFS_FAR1) begin
                    prdata_q[PC_W-1:0] <= far_target_one_q;
                end else if (apb.paddr == OFS_FAR2) begin
                    prdata_q[PC_W-1:0] <= far_target_two_q;
                end else if (apb.paddr == OFS_IMM) begin
                    prdata_q[15:0] <= immediate_operand_register_q;
                end else if (apb.paddr == OFS_PC) begin
                    prdata_q[PC_W-1:0] <= program_counter_q;
                end else if (apb.paddr == OFS_RET) begin
                    prdata_q[PC_W-1:0] <= return_addr_q;
                end else if (apb.paddr == OFS_STATE) begin
                    prdata_q[2:0] <= {shortcut_q, state_q == ST_MEM_WAIT};
                end else if (apb.paddr[7:4] == OFS_TC0[7:4] && apb.paddr[3:2] == 2'h0) begin
                    prdata_q[15:0] <= terminal_count_q[0];
                end else if (apb.paddr[7:4] == OFS_TC0[7:4] && apb.paddr[3:2] == 2'h1) begin
                    prdata_q[15:0] <= terminal_count_q[1];
                end else if (apb.paddr[7:4] == OFS_TC0[7:4] && apb.paddr[3:2] == 2'h2) begin
                    prdata_q[15:0] <= terminal_count_q[2];
                end else if (apb.paddr[7:4] == OFS_TC0[7:4]) begin
                    prdata_q[15:0] <= terminal_count_q[3];
                end else begin
                    pslverr_q <= 1'b1;
                end
            end
            // writes land on the completing edge only
            if (apb_done && apb.pwrite) begin
                if (apb.paddr == OFS_CTRL) begin
                    decode_en_q <= apb.pwdata[0];
                end else if (apb.paddr == OFS_FAR1) begin
                    far_target_one_q <= apb.pwdata[PC_W-1:0];
                end else if (apb.paddr == OFS_FAR2) begin
                    far_target_two_q <= apb.pwdata[PC_W-1:0];
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_jmp_taken;
        accept && is_jmp && jmp_met |=> program_counter_q ==
            mbld_pc_t'($past(instr.addr) + mbld_pc_t'($signed($past(w[OFS_HI:OFS_LO]))));
    endproperty
    a_jmp_taken: assert property (p_jmp_taken) else $error("jump target wrong");

    property p_jmp_fall;
        accept && is_jmp && !jmp_met |=> program_counter_q == $past(instr.addr) + 10'h001;
    endproperty
    a_jmp_fall: assert property (p_jmp_fall) else $error("untaken jump wrong");

    property p_far_call;
        accept && is_jtsf |=> program_counter_q ==
            ($past(w[FAR_BIT]) ? $past(far_target_two_q) : $past(far_target_one_q));
    endproperty
    a_far_call: assert property (p_far_call) else $error("far call target wrong");

    property p_call_ret;
        accept && (is_jtsf || is_jtsr) |=> return_addr_q == $past(instr.addr);
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return address not saved");

    property p_rel_call;
        accept && is_jtsr |=> program_counter_q ==
            mbld_pc_t'($past(instr.addr) + mbld_pc_t'($signed($past(w[OFS_HI:OFS_LO]))));
    endproperty
    a_rel_call: assert property (p_rel_call) else $error("relative call wrong");

    property p_ldca_val;
        accept && is_ldca |=> terminal_count_q[$past(tc_sel)] ==
            $past(alu_regs[source_reg_index]);
    endproperty
    a_ldca_val: assert property (p_ldca_val) else $error("ALU count load wrong");

    property p_clr;
        accept && is_ldca |=> counter_clear_q == ($past(clr_flag) ? 4'h1 << $past(tc_sel) : 4'h0);
    endproperty
    a_clr: assert property (p_clr) else $error("counter clear pulse wrong");

    property p_sc_on;
        accept && is_ldca && sc1_action == SC_ON && sc2_action == SC_TOGGLE
            |=> shortcut_q[0] && shortcut_q[1] != $past(shortcut_q[1]);
    endproperty
    a_sc_on: assert property (p_sc_on) else $error("shortcut action wrong");

    property p_mem_addr;
        accept && is_ldcd |=> dram_rd_q && !instr_ready_q &&
            dram_addr_q == ($past(w[MODE_BIT]) ? $past(dram_field) + $past(index_base)
                                               : $past(dram_field));
    endproperty
    a_mem_addr: assert property (p_mem_addr) else $error("data RAM address wrong");

    property p_mem_load;
        ce && state_q == ST_MEM_WAIT && dram_rvalid
            |=> terminal_count_q[$past(mem_sel_q)] == $past(dram_rdata) && done_q;
    endproperty
    a_mem_load: assert property (p_mem_load) else $error("memory count load wrong");

    property p_ldih;
        accept && is_ldih |=> immediate_operand_register_q[15:8] == $past(w[LIT_HI:LIT_LO])
            && ($past(w[BCLR_BIT]) ? immediate_operand_register_q[7:0] == 8'h00
                : $stable(immediate_operand_register_q[7:0]));
    endproperty
    a_ldih: assert property (p_ldih) else $error("upper byte load wrong");

    property p_ldil;
        accept && is_ldil |=> immediate_operand_register_q[7:0] == $past(w[LIT_HI:LIT_LO])
            && ($past(w[BCLR_BIT]) ? immediate_operand_register_q[15:8] == 8'h00
                : $stable(immediate_operand_register_q[15:8]));
    endproperty
    a_ldil: assert property (p_ldil) else $error("lower byte load wrong");

    c_jmp_taken: cover property (accept && is_jmp && jmp_met);
    c_far_call:  cover property (accept && is_jtsf);
    c_mem_load:  cover property (ce && state_q == ST_MEM_WAIT && dram_rvalid);
    c_toggle:    cover property (accept && is_ldca && sc1_action == SC_TOGGLE);

endmodule

// [test/mbld_dram_model.sv]
/*
 * Data RAM read port model: answers each read pulse after a delay set by the bench.
 * Assumes one read outstanding at a time, as the decoder never issues another.
 */
`timescale 1ns/100ps
module mbld_dram_model (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // read request
    input  wire logic                  rd,
    input  wire mbld_pkg::mbld_daddr_t addr,
    input  wire logic [3:0]            lat,
    // read answer
    output logic                       rvalid,
    output mbld_pkg::mbld_word_t       rdata
);
    import mbld_pkg::*;
    logic [4:0]  cnt_q;
    mbld_daddr_t addr_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= 5'h00;
            addr_q <= 6'h00;
            rvalid <= 1'b0;
            rdata  <= 16'h0000;
        end else begin
            rvalid <= 1'b0;
            // data is stale outside the answer cycle, so keep it moving
            rdata  <= ~rdata;
            if (rd) begin
                cnt_q  <= {1'b0, lat} + 5'h01;
                addr_q <= addr;
            end else if (cnt_q > 5'h01) begin
                cnt_q <= cnt_q - 5'h01;
            end else if (cnt_q == 5'h01) begin
                cnt_q  <= 5'h00;
                rvalid <= 1'b1;
                rdata  <= {addr_q, 4'h9, addr_q};
            end
        end
    end
endmodule

// [test/microcore_branch_load_decode_tb_top.sv]
/*
 * Bench: random instruction stream and APB accesses checked against a scoreboard.
 * Assumes the data RAM model on the read port; ce drops only with no read outstanding.
 */
`timescale 1ns/100ps
module microcore_branch_load_decode_tb_top;
    import mbld_pkg::*;
    typedef struct packed {
        logic hit; mbld_pc_t pc; mbld_pc_t ret; mbld_word_t imm;
        logic [1:0] sc; logic [3:0] clr; mbld_word_t [3:0] tc;
    } mbld_exp_s;
    logic             clk, resetn, ce, instr_ready_q, done_q, hit_q, dram_rd_q;
    logic             dram_rvalid, pready_q, pslverr_q;
    mbld_instr_s      instr;
    logic [15:0]      status_word;
    mbld_word_t [7:0] alu_regs;
    mbld_daddr_t      index_base, dram_addr_q;
    mbld_apb_req_s    apb;
    logic [3:0]       lat, clr_q;
    mbld_word_t       dram_rdata, imm_q;
    mbld_pc_t         pc_q, ret_q, far1, far2;
    mbld_word_t [3:0] tc_q;
    logic [1:0]       sc_q;
    logic [31:0]      prdata_q, seed, r;
    int               error_cnt, check_count;
    mbld_exp_s        q[$], m;
    mbld_word_t       msk[8] = '{JMP_MASK, JTSF_MASK, JTSR_MASK, LDCA_MASK,
                                 LDCD_MASK, LDIH_MASK, LDIL_MASK, 16'h0000};
    mbld_word_t       val[8] = '{JMP_VAL, JTSF_VAL, JTSR_VAL, LDCA_VAL,
                                 LDCD_VAL, LDIH_VAL, LDIL_VAL, 16'h0000};
    mbld_decode mbld_decode_i (.clk, .resetn, .ce, .instr, .instr_ready_q, .done_q,
        .hit_q, .status_word, .alu_regs, .index_base, .dram_addr_q, .dram_rd_q,
        .dram_rvalid, .dram_rdata, .program_counter_q(pc_q), .return_addr_q(ret_q),
        .immediate_operand_register_q(imm_q), .terminal_count_q(tc_q),
        .counter_clear_q(clr_q), .shortcut_q(sc_q), .apb, .prdata_q, .pready_q, .pslverr_q);
    mbld_dram_model mbld_dram_model_i (.clk, .resetn, .rd(dram_rd_q), .addr(dram_addr_q),
        .lat, .rvalid(dram_rvalid), .rdata(dram_rdata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic act(logic s, logic [1:0] c);
        return c[1] ? (c[0] ? !s : 1'b1) : (c[0] ? 1'b0 : s);
    endfunction
    function automatic void tcload(mbld_word_t w, mbld_word_t v, mbld_pc_t a);
        m.tc[w[7:6]] = v;
        m.clr = w[12] ? 4'h1 << w[7:6] : 4'h0;
        m.sc[0] = act(m.sc[0], w[11:10]);
        m.sc[1] = act(m.sc[1], w[9:8]);
        m.pc = a + 10'h001;
    endfunction
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 60);
        if (s !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            input logic [32:0] exp);
        @(posedge clk);
        apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        wait_hi(pready_q);
        if (!wr) check({pslverr_q, prdata_q}, exp);
        apb <= '0;
    endtask
    task automatic exec(input mbld_word_t w, input mbld_pc_t a);
        mbld_word_t [7:0] ar;
        mbld_daddr_t      da;
        r = rnd();
        ar = {rnd(), rnd(), rnd(), rnd()};
        m.clr = 4'h0;
        m.hit = 1'b1;
        if ((w & JMP_MASK) == JMP_VAL)
            m.pc = (r[w[8:5]] == w[9]) ? a + {{5{w[4]}}, w[4:0]} : a + 10'h001;
        else if ((w & JTSF_MASK) == JTSF_VAL) begin
            m.ret = a;
            m.pc = w[3] ? far2 : far1;
        end else if ((w & JTSR_MASK) == JTSR_VAL) begin
            m.ret = a;
            m.pc = a + {{5{w[4]}}, w[4:0]};
        end else if ((w & LDCA_MASK) == LDCA_VAL)
            tcload(w, ar[w[5:3]], a);
        else if ((w & LDCD_MASK) == LDCD_VAL) begin
            da = w[5:0] + (w[13] ? r[21:16] : 6'h00);
            tcload(w, {da, 4'h9, da}, a);
        end else if ((w & LDIH_MASK) == LDIH_VAL) begin
            m.imm = {w[9:2], w[10] ? 8'h00 : m.imm[7:0]};
            m.pc = a + 10'h001;
        end else if ((w & LDIL_MASK) == LDIL_VAL) begin
            m.imm = {w[10] ? 8'h00 : m.imm[15:8], w[9:2]};
            m.pc = a + 10'h001;
        end else m.hit = 1'b0;
        q.push_back(m);
        @(posedge clk);
        instr <= '{1'b1, w, a};
        status_word <= r[15:0];
        index_base <= r[21:16];
        lat <= r[25:22];
        alu_regs <= ar;
        wait_hi(instr_ready_q);
        instr.valid <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (done_q === 1'b1) begin
            check({hit_q, pc_q, ret_q, imm_q, sc_q, clr_q, tc_q}, q.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {resetn, instr, status_word, alu_regs, index_base, apb, lat} = '0;
        ce = 1'b1;
        seed = 32'd71;
        m = '0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        check({hit_q, pc_q, ret_q, imm_q, sc_q, clr_q, tc_q}, '0);
        apb_xfer(1'b0, OFS_CTRL, 32'h0, {1'b0, 32'h1});
        r = rnd();
        far1 = r[9:0];
        far2 = r[19:10];
        apb_xfer(1'b1, OFS_FAR1, {22'h0, far1}, '0);
        apb_xfer(1'b1, OFS_FAR2, {22'h0, far2}, '0);
        apb_xfer(1'b0, OFS_FAR2, 32'h0, {11'h0, far2});
        apb_xfer(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0});
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            exec((r[31:16] & ~msk[r[2:0]]) | val[r[2:0]], r[12:3]);
        end
        for (int i = 0; i < 60 && q.size() > 0; i++) @(posedge clk);
        check(q.size(), 0);
        // decoding off and ce low: a waiting instruction must leave no trace
        apb_xfer(1'b1, OFS_CTRL, 32'h0, '0);
        @(posedge clk);
        ce <= 1'b0;
        instr <= '{1'b1, LDIH_VAL | 16'h07FC, 10'h155};
        repeat (4) @(posedge clk);
        check({pc_q, imm_q}, {m.pc, m.imm});
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        check({pc_q, imm_q, instr_ready_q}, {m.pc, m.imm, 1'b0});
        instr.valid <= 1'b0;
        apb_xfer(1'b1, OFS_CTRL, 32'h1, '0);
        apb_xfer(1'b0, OFS_PC, 32'h0, {23'h0, m.pc});
        complete_run();
    end
endmodule
